// ### logic/rsc_reset_ctrl.sv
// reset combiner, delay stretcher and sleep power gating
`include "rsc_consts.svh"
`default_nettype none
module rsc_reset_ctrl #(
	parameter logic [`RSC_DLY_W-1:0] DLY_SHORT = `RSC_DLY_SHORT,
	parameter logic [`RSC_DLY_W-1:0] DLY_MID = `RSC_DLY_MID,
	parameter logic [`RSC_DLY_W-1:0] DLY_LONG = `RSC_DLY_LONG
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// reset sources
	input wire logic PWR_BELOW_POR_I,
	input wire logic RESET_PIN_N_I,
	input wire logic WDOG_EXPIRE_I,
	input wire logic WDOG_ENABLE_I,
	input wire logic SUPPLY_BELOW_27_I,
	input wire logic SUPPLY_BELOW_40_I,
	input wire logic SCAN_RESET_REG_I,
	// fuses, programmed reads zero
	input wire logic SUPPLY_DROP_ENABLE_FUSE_N_I,
	input wire logic SUPPLY_DROP_LEVEL_FUSE_N_I,
	input wire rsc_pkg::rsc_clock_select_fuses_t CLOCK_SELECT_FUSES_I,
	input wire logic ON_CHIP_DEBUG_FUSE_N_I,
	input wire logic SCAN_PORT_ENABLE_FUSE_N_I,
	// control bits
	input wire logic SCAN_PORT_DISABLE_BIT_I,
	input wire logic SLEEP_ACTIVE_I,
	input wire rsc_pkg::rsc_sleep_t SLEEP_SELECT_FIELD_I,
	input wire logic ADC_ENABLE_I,
	input wire logic COMP_ENABLE_I,
	input wire logic COMP_USES_REF_I,
	input wire logic SCAN_SHIFTING_I,
	input wire logic SCAN_TDO_I,
	// reset outputs
	output logic PORT_RESET_O,
	output logic CORE_RESET_O,
	output logic FETCH_FROM_VECTOR_O,
	// power gating outputs
	output logic SUPPLY_DROP_ON_O,
	output logic WDOG_RUN_O,
	output logic ADC_ON_O,
	output logic ADC_EXTENDED_O,
	output logic COMP_ON_O,
	output logic REF_ON_O,
	output logic INPUT_BUF_EN_O,
	output logic MAIN_CLK_RUN_O,
	output logic SCAN_PORT_EN_O,
	output logic TDO_OUT_O,
	output logic TDO_OE_N_O
);
	import rsc_pkg::*;

	// limitations a user must know:
	// - the pin and supply-drop filters count clock cycles, so with the clock
	//   stopped those two sources only reach the ports once the clock returns;
	//   power-up and the scan reset register act on the ports without a clock
	// - filter lengths assume the nominal clock period; a slower clock makes the
	//   accepted pulse longer, never shorter, so short glitches stay refused
	// - the watchdog pulse is taken from the rising edge of the expiry level,
	//   so a held expiry gives one reset, not a stream of them
	// - every source, filtered or not, funnels into one request so that a
	//   reassertion during the stretch always restarts the full time-out

	function automatic logic [`RSC_DLY_W-1:0] dly_for(input rsc_clock_select_fuses_t sel);
		logic [`RSC_DLY_W-1:0] d;
		d = DLY_LONG;
		case (sel[1:0])
			2'h0: d = DLY_SHORT;
			2'h1: d = DLY_MID;
			default: d = DLY_LONG;
		endcase
		return d;
	endfunction : dly_for

	// is this sleep mode one where io and converter clocks both stop
	function automatic logic deep_sleep(input rsc_sleep_t sm);
		return !(sm == `RSC_SM_IDLE || sm == `RSC_SM_ADCNR);
	endfunction : deep_sleep

	logic [`RSC_FILT_W-1:0] pin_cnt_r, pin_cnt_nxt;
	logic [`RSC_FILT_W-1:0] drop_cnt_r, drop_cnt_nxt;
	logic pin_rst_r, pin_rst_nxt;
	logic drop_rst_r, drop_rst_nxt;
	logic wdog_pulse_r, wdog_pulse_nxt;
	logic wdog_exp_d_r, wdog_exp_d_nxt;
	logic [`RSC_DLY_W-1:0] dly_r, dly_nxt;
	rsc_state_e st_r, st_nxt;
	logic adc_prev_r, adc_prev_nxt;
	logic adc_ext_r, adc_ext_nxt;
	logic drop_en, below_trip, async_src, any_req;
	logic sup_on_r, wd_on_r, adc_on_r, cmp_on_r, ref_on_r, ibuf_r, mclk_r, scan_en_r, tdo_r, tdo_oe_n_r;

	assign drop_en = SUPPLY_DROP_ENABLE_FUSE_N_I == `RSC_FUSE_PROG;
	// unprogrammed level fuse picks the low trip point
	assign below_trip = (SUPPLY_DROP_LEVEL_FUSE_N_I == `RSC_FUSE_PROG) ? SUPPLY_BELOW_40_I
		: SUPPLY_BELOW_27_I;

	// sources that must act without a clock; filtered pin and drop are registered versions
	assign async_src = PWR_BELOW_POR_I | SCAN_RESET_REG_I | pin_rst_r | drop_rst_r;
	assign any_req = async_src | wdog_pulse_r;

	// the port reset is a gate, not a flop: it must act with the clock stopped
	assign PORT_RESET_O = async_src | wdog_pulse_r | CORE_RESET_O;

	always_comb begin
		pin_cnt_nxt = pin_cnt_r;
		pin_rst_nxt = pin_rst_r;
		drop_cnt_nxt = drop_cnt_r;
		drop_rst_nxt = drop_rst_r;
		// pin must stay low past the minimum width before it counts
		if (RESET_PIN_N_I) begin
			pin_cnt_nxt = '0;
			pin_rst_nxt = 1'b0;
		end else if (pin_cnt_r >= (`RSC_FILT_W)'(`RSC_PIN_MIN_CYC)) begin
			pin_rst_nxt = 1'b1;
		end else begin
			pin_cnt_nxt = pin_cnt_r + 1'b1;
		end
		// short supply dips are filtered out
		if (!(drop_en && below_trip)) begin
			drop_cnt_nxt = '0;
			drop_rst_nxt = 1'b0;
		end else if (drop_cnt_r >= (`RSC_FILT_W)'(`RSC_DROP_MIN_CYC)) begin
			drop_rst_nxt = 1'b1;
		end else begin
			drop_cnt_nxt = drop_cnt_r + 1'b1;
		end
		wdog_exp_d_nxt = WDOG_EXPIRE_I;
		// one cycle pulse on rising expiry, only if enabled
		wdog_pulse_nxt = WDOG_EXPIRE_I & ~wdog_exp_d_r & WDOG_ENABLE_I;
	end

	always_comb begin
		st_nxt = st_r;
		dly_nxt = dly_r;
		case (st_r)
			RSC_HOLD: begin
				if (!any_req) begin
					st_nxt = RSC_STRETCH;
					dly_nxt = dly_for(CLOCK_SELECT_FUSES_I);
				end
			end
			RSC_STRETCH: begin
				if (any_req) begin
					st_nxt = RSC_HOLD;
				end else if (dly_r <= (`RSC_DLY_W)'(1)) begin
					st_nxt = RSC_RUN;
					dly_nxt = '0;
				end else begin
					dly_nxt = dly_r - 1'b1;
				end
			end
			RSC_RUN: begin
				if (any_req) begin
					st_nxt = RSC_HOLD;
				end
			end
			default: st_nxt = RSC_HOLD;
		endcase
	end

	always_comb begin
		adc_prev_nxt = ADC_ENABLE_I;
		adc_ext_nxt = adc_ext_r;
		// enable after off marks the next conversion as extended; cleared when disabled again
		if (ADC_ENABLE_I && !adc_prev_r) begin
			adc_ext_nxt = 1'b1;
		end else if (!ADC_ENABLE_I) begin
			adc_ext_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pin_cnt_r <= '0;
			pin_rst_r <= 1'b0;
			drop_cnt_r <= '0;
			drop_rst_r <= 1'b0;
			wdog_pulse_r <= 1'b0;
			wdog_exp_d_r <= 1'b0;
			st_r <= RSC_HOLD;
			dly_r <= '0;
			adc_prev_r <= 1'b0;
			adc_ext_r <= 1'b0;
		end else begin
			pin_cnt_r <= pin_cnt_nxt;
			pin_rst_r <= pin_rst_nxt;
			drop_cnt_r <= drop_cnt_nxt;
			drop_rst_r <= drop_rst_nxt;
			wdog_pulse_r <= wdog_pulse_nxt;
			wdog_exp_d_r <= wdog_exp_d_nxt;
			st_r <= st_nxt;
			dly_r <= dly_nxt;
			adc_prev_r <= adc_prev_nxt;
			adc_ext_r <= adc_ext_nxt;
		end
	end

	// registered outputs; the core restarts from the vector when reset lifts
	logic core_rst_r, core_rst_nxt;
	logic fetch_r, fetch_nxt;

	always_comb begin
		// taken from the next state so release and fetch leave on the same edge
		core_rst_nxt = (st_nxt != RSC_RUN);
		fetch_nxt = (st_nxt == RSC_RUN) && (st_r != RSC_RUN);
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			core_rst_r <= 1'b1;
			fetch_r <= 1'b0;
		end else begin
			core_rst_r <= core_rst_nxt;
			fetch_r <= fetch_nxt;
		end
	end

	assign CORE_RESET_O = core_rst_r;
	assign FETCH_FROM_VECTOR_O = fetch_r;

	// sleep decode and scan port qualifiers shared by the gating outputs
	logic scan_en_c, sleep_deep, cmp_c, adc_c;
	logic dbg_fuse_c, clk_stop_mode_c, scan_drive_c;
	assign sleep_deep = SLEEP_ACTIVE_I && deep_sleep(SLEEP_SELECT_FIELD_I);
	assign scan_en_c = (SCAN_PORT_ENABLE_FUSE_N_I == `RSC_FUSE_PROG) && !SCAN_PORT_DISABLE_BIT_I;
	assign cmp_c = COMP_ENABLE_I && !sleep_deep;
	assign adc_c = ADC_ENABLE_I;
	assign dbg_fuse_c = ON_CHIP_DEBUG_FUSE_N_I == `RSC_FUSE_PROG;
	// power-down and power-save stop the main oscillator unless debug holds it
	assign clk_stop_mode_c = SLEEP_ACTIVE_I && (SLEEP_SELECT_FIELD_I == `RSC_SM_PDOWN
		|| SLEEP_SELECT_FIELD_I == `RSC_SM_PSAVE);
	// the pin is only driven while the port is really shifting
	assign scan_drive_c = scan_en_c && SCAN_SHIFTING_I;

	// next values of the registered gating outputs
	logic adc_ext_o_r;
	logic sup_on_nxt, wd_on_nxt, adc_on_nxt, adc_ext_o_nxt, cmp_on_nxt, ref_on_nxt;
	logic ibuf_nxt, mclk_nxt, scan_en_nxt, tdo_nxt, tdo_oe_n_nxt;

	always_comb begin
		sup_on_nxt = drop_en;
		wd_on_nxt = WDOG_ENABLE_I;
		adc_on_nxt = adc_c;
		adc_ext_o_nxt = adc_ext_nxt;
		cmp_on_nxt = cmp_c;
		// a comparator tied to the reference keeps it on even in deep sleep
		ref_on_nxt = drop_en | adc_c | (COMP_ENABLE_I & COMP_USES_REF_I);
		// wake-up pins have their own buffers outside this gate
		ibuf_nxt = !sleep_deep;
		mclk_nxt = 1'b1;
		if (clk_stop_mode_c) begin
			// debug costs the oscillator; dropping either fuse or the port lets it stop
			mclk_nxt = dbg_fuse_c && scan_en_c;
		end
		scan_en_nxt = scan_en_c;
		tdo_nxt = SCAN_TDO_I;
		tdo_oe_n_nxt = 1'b1;
		if (scan_drive_c) begin
			tdo_oe_n_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			sup_on_r <= 1'b0;
			wd_on_r <= 1'b0;
			adc_on_r <= 1'b0;
			adc_ext_o_r <= 1'b0;
			cmp_on_r <= 1'b0;
			ref_on_r <= 1'b0;
			ibuf_r <= 1'b1;
			mclk_r <= 1'b1;
			scan_en_r <= 1'b0;
			tdo_r <= 1'b0;
			tdo_oe_n_r <= 1'b1;
		end else begin
			sup_on_r <= sup_on_nxt;
			wd_on_r <= wd_on_nxt;
			adc_on_r <= adc_on_nxt;
			adc_ext_o_r <= adc_ext_o_nxt;
			cmp_on_r <= cmp_on_nxt;
			ref_on_r <= ref_on_nxt;
			ibuf_r <= ibuf_nxt;
			mclk_r <= mclk_nxt;
			scan_en_r <= scan_en_nxt;
			tdo_r <= tdo_nxt;
			tdo_oe_n_r <= tdo_oe_n_nxt;
		end
	end

	// every gating output is a plain flop, so no decode glitch reaches the analog side
	assign SUPPLY_DROP_ON_O = sup_on_r;
	assign WDOG_RUN_O = wd_on_r;
	assign ADC_ON_O = adc_on_r;
	assign ADC_EXTENDED_O = adc_ext_o_r;
	assign COMP_ON_O = cmp_on_r;
	assign REF_ON_O = ref_on_r;
	assign INPUT_BUF_EN_O = ibuf_r;
	assign MAIN_CLK_RUN_O = mclk_r;
	assign SCAN_PORT_EN_O = scan_en_r;
	assign TDO_OUT_O = tdo_r;
	assign TDO_OE_N_O = tdo_oe_n_r;
endmodule : rsc_reset_ctrl
`default_nettype wire

// ### logic/rsc_consts.svh
// constants for the reset and sleep power controller
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// reset pin minimum pulse width in ns and cycles (least time, rounded up)
`define RSC_CLK_PERIOD_NS 100
`define RSC_PIN_MIN_NS 1500
`define RSC_PIN_MIN_CYC ((`RSC_PIN_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
// supply-drop minimum low period in ns and cycles
`define RSC_DROP_MIN_NS 2000
`define RSC_DROP_MIN_CYC ((`RSC_DROP_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_FILT_W 5
// delay counter width and default time-outs per clock-select code
`define RSC_DLY_W 20
`define RSC_DLY_SHORT 20'h0_0006
`define RSC_DLY_MID 20'h0_0400
`define RSC_DLY_LONG 20'h1_0000
// fuse polarity: programmed reads as zero
`define RSC_FUSE_PROG 1'b0
// sleep select codes
`define RSC_SM_IDLE 3'h0
`define RSC_SM_ADCNR 3'h1
`define RSC_SM_PDOWN 3'h2
`define RSC_SM_PSAVE 3'h3
`define RSC_SM_STBY 3'h6
`define RSC_SM_XSTBY 3'h7

`endif

// ### logic/rsc_pkg.sv
// types for the reset and sleep power controller
`default_nettype none
package rsc_pkg;
	typedef enum logic [1:0] {
		RSC_HOLD,
		RSC_STRETCH,
		RSC_RUN
	} rsc_state_e;
	typedef logic [2:0] rsc_sleep_t;
	typedef logic [3:0] rsc_clock_select_fuses_t;
endpackage : rsc_pkg
`default_nettype wire

// ### test/rsc_reset_ctrl_properties.sv
// assertions for the reset and sleep power controller
`default_nettype none
module rsc_reset_ctrl_properties #(
	parameter int DLY_MIN = 6
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PWR_BELOW_POR_I,
	input wire logic RESET_PIN_N_I,
	input wire logic SCAN_RESET_REG_I,
	input wire logic SUPPLY_DROP_ENABLE_FUSE_N_I,
	input wire logic SLEEP_ACTIVE_I,
	input wire rsc_pkg::rsc_sleep_t SLEEP_SELECT_FIELD_I,
	input wire logic ADC_ENABLE_I,
	input wire logic COMP_ENABLE_I,
	input wire logic COMP_USES_REF_I,
	input wire logic WDOG_ENABLE_I,
	input wire logic SCAN_SHIFTING_I,
	input wire logic PORT_RESET_O,
	input wire logic CORE_RESET_O,
	input wire logic FETCH_FROM_VECTOR_O,
	input wire logic WDOG_RUN_O,
	input wire logic COMP_ON_O,
	input wire logic REF_ON_O,
	input wire logic INPUT_BUF_EN_O,
	input wire logic TDO_OE_N_O
);
	import rsc_pkg::*;
	logic [7:0] quiet_r;
	logic [7:0] quiet_nxt;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// cycles since the last pin, power-up or scan request; saturates
	always_comb begin
		quiet_nxt = (quiet_r == 8'hff) ? quiet_r : quiet_r + 8'h01;
		if (PWR_BELOW_POR_I || SCAN_RESET_REG_I || !RESET_PIN_N_I)
			quiet_nxt = 8'h00;
	end
	always_ff @(posedge CLK_I) begin
		quiet_r <= RST_I ? 8'h00 : quiet_nxt;
	end
	sequence s_pulse;
		FETCH_FROM_VECTOR_O ##1 !FETCH_FROM_VECTOR_O;
	endsequence
	por_port_a: assert property (PWR_BELOW_POR_I |-> PORT_RESET_O)
		else $error("port reset missing under low supply");
	core_port_a: assert property (CORE_RESET_O |-> PORT_RESET_O)
		else $error("ports free while core held");
	scan_hold_a: assert property (SCAN_RESET_REG_I |=> CORE_RESET_O)
		else $error("core runs while scan reset held");
	stretch_len_a: assert property ($fell(CORE_RESET_O) |-> quiet_r >= DLY_MIN - 1)
		else $error("release before delay ran out");
	vector_fetch_a: assert property ($fell(CORE_RESET_O) |-> s_pulse)
		else $error("no single fetch pulse at release");
	wdog_run_a: assert property (!$past(RST_I) |-> WDOG_RUN_O == $past(WDOG_ENABLE_I))
		else $error("watchdog run differs from enable");
	comp_off_a: assert property (SLEEP_ACTIVE_I && SLEEP_SELECT_FIELD_I[1] |=> !COMP_ON_O)
		else $error("comparator on in deep sleep");
	ref_need_a: assert property (!$past(RST_I) |-> REF_ON_O == $past(!SUPPLY_DROP_ENABLE_FUSE_N_I
		|| ADC_ENABLE_I || (COMP_ENABLE_I && COMP_USES_REF_I)))
		else $error("reference power wrong");
	buf_off_a: assert property (SLEEP_ACTIVE_I && SLEEP_SELECT_FIELD_I[1] |=> !INPUT_BUF_EN_O)
		else $error("input buffers on in deep sleep");
	tdo_float_a: assert property (!SCAN_SHIFTING_I |=> TDO_OE_N_O)
		else $error("scan output driven while idle");
endmodule : rsc_reset_ctrl_properties
bind rsc_reset_ctrl rsc_reset_ctrl_properties #(.DLY_MIN(DLY_SHORT)) rsc_reset_ctrl_properties_i (.*);
`default_nettype wire

// ### test/rsc_supply_model.sv
// supply monitor and reset pin driver beside the controller
`default_nettype none
module rsc_supply_model (
	input wire logic clk_i,
	input wire logic [15:0] vcc_mv_i,
	input wire logic pin_low_i,
	output logic por_o,
	output logic below27_o,
	output logic below40_o,
	output logic pin_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		por_o = 1'b0;
		below27_o = 1'b0;
		below40_o = 1'b0;
		pin_n_o = 1'b1;
	end
	always @(posedge clk_i) begin
		por_o <= vcc_mv_i < 16'h0578;
		below27_o <= vcc_mv_i < 16'h0A8C;
		below40_o <= vcc_mv_i < 16'h0FA0;
		pin_n_o <= !pin_low_i;
	end
endmodule : rsc_supply_model
`default_nettype wire

// ### test/tb_rsc_reset_ctrl.sv
// self-checking bench for the reset and sleep power controller
`default_nettype none
module tb_rsc_reset_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import rsc_pkg::*;
	logic CLK_I = 0, RST_I = 1, WDOG_EXPIRE_I = 0, WDOG_ENABLE_I = 0, SCAN_RESET_REG_I = 0, SLEEP_ACTIVE_I = 0;
	logic SUPPLY_DROP_ENABLE_FUSE_N_I = 1, SUPPLY_DROP_LEVEL_FUSE_N_I = 1, ON_CHIP_DEBUG_FUSE_N_I = 0;
	logic SCAN_PORT_ENABLE_FUSE_N_I = 0, SCAN_PORT_DISABLE_BIT_I = 0, ADC_ENABLE_I = 0, COMP_ENABLE_I = 0;
	logic COMP_USES_REF_I = 0, SCAN_SHIFTING_I = 0, SCAN_TDO_I = 0, pin_low = 0;
	logic PWR_BELOW_POR_I, RESET_PIN_N_I, SUPPLY_BELOW_27_I, SUPPLY_BELOW_40_I;
	logic PORT_RESET_O, CORE_RESET_O, FETCH_FROM_VECTOR_O, SUPPLY_DROP_ON_O, WDOG_RUN_O, ADC_ON_O, ADC_EXTENDED_O;
	logic COMP_ON_O, REF_ON_O, INPUT_BUF_EN_O, MAIN_CLK_RUN_O, SCAN_PORT_EN_O, TDO_OUT_O, TDO_OE_N_O;
	rsc_clock_select_fuses_t CLOCK_SELECT_FUSES_I = 4'h0;
	rsc_sleep_t SLEEP_SELECT_FIELD_I = 3'h0;
	logic [15:0] vcc = 16'h1388;
	int bad_count = 0;
	int checks_done = 0;
	// long time-out cut to 16 cycles to keep the run short
	rsc_reset_ctrl #(.DLY_MID(20'h0_000A), .DLY_LONG(20'h0_0010)) rsc_reset_ctrl_i (.*);
	rsc_supply_model rsc_supply_model_i (.clk_i(CLK_I), .vcc_mv_i(vcc), .pin_low_i(pin_low), .por_o(PWR_BELOW_POR_I),
		.below27_o(SUPPLY_BELOW_27_I), .below40_o(SUPPLY_BELOW_40_I), .pin_n_o(RESET_PIN_N_I));
	always #50 CLK_I = ~CLK_I;
	task chk(string n, logic s, logic e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %b seen %b", n, e, s);
		end
	endtask : chk
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// holds a source for len cycles, then counts how long the core stays held
	task hit(string n, logic [15:0] mv, logic [2:0] src, int len, logic e, int d);
		int k;
		logic h;
		h = 0;
		k = 0;
		@(posedge CLK_I);
		vcc <= mv;
		pin_low <= src[0];
		SCAN_RESET_REG_I <= src[1];
		WDOG_EXPIRE_I <= src[2];
		repeat (len) begin
			@(negedge CLK_I);
			h |= CORE_RESET_O !== 1'b0;
		end
		@(posedge CLK_I);
		vcc <= 16'h1388;
		pin_low <= 0;
		SCAN_RESET_REG_I <= 0;
		WDOG_EXPIRE_I <= 0;
		repeat (300) begin
			@(negedge CLK_I);
			if (CORE_RESET_O !== 1'b0) begin
				h = 1;
				k++;
			end
		end
		chk(n, h, e);
		if (e)
			chk(n, k >= d && k <= d + 8, 1'b1);
		$display("%s done", n);
	endtask : hit
	task t_sources;
		hit("power-up", 16'h03E8, 3'h0, 5, 1, 6);
		@(posedge CLK_I);
		CLOCK_SELECT_FUSES_I <= 4'h1;
		hit("short pin", 16'h1388, 3'h1, 10, 0, 0);
		hit("long pin", 16'h1388, 3'h1, 20, 1, 10);
		hit("scan reg", 16'h1388, 3'h2, 40, 1, 10);
		@(posedge CLK_I);
		CLOCK_SELECT_FUSES_I <= 4'h2;
		hit("wdog off", 16'h1388, 3'h4, 2, 0, 0);
		@(posedge CLK_I);
		WDOG_ENABLE_I <= 1;
		hit("wdog on", 16'h1388, 3'h4, 2, 1, 16);
	endtask : t_sources
	task t_drop;
		@(posedge CLK_I);
		CLOCK_SELECT_FUSES_I <= 4'h0;
		hit("drop fuse off", 16'h07D0, 3'h0, 40, 0, 0);
		@(posedge CLK_I);
		SUPPLY_DROP_ENABLE_FUSE_N_I <= 0;
		hit("above low level", 16'h0BB8, 3'h0, 40, 0, 0);
		hit("short drop", 16'h09C4, 3'h0, 10, 0, 0);
		hit("long drop", 16'h09C4, 3'h0, 30, 1, 6);
		@(posedge CLK_I);
		SUPPLY_DROP_LEVEL_FUSE_N_I <= 0;
		hit("high level", 16'h0BB8, 3'h0, 30, 1, 6);
	endtask : t_drop
	task settle;
		repeat (3) @(negedge CLK_I);
	endtask : settle
	task t_sleep;
		rsc_sleep_t m[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
		@(posedge CLK_I);
		SLEEP_ACTIVE_I <= 1;
		ADC_ENABLE_I <= 1;
		COMP_ENABLE_I <= 1;
		foreach (m[i]) begin
			@(posedge CLK_I);
			SLEEP_SELECT_FIELD_I <= m[i];
			settle();
			chk("comparator", COMP_ON_O, !m[i][1]);
			chk("input buffers", INPUT_BUF_EN_O, !m[i][1]);
			chk("kept on", ADC_ON_O & WDOG_RUN_O & SUPPLY_DROP_ON_O & REF_ON_O, 1'b1);
			if (m[i][2:1] == 2'b01)
				chk("debug clock", MAIN_CLK_RUN_O, 1'b1);
		end
		@(posedge CLK_I);
		SCAN_PORT_DISABLE_BIT_I <= 1;
		ADC_ENABLE_I <= 0;
		SUPPLY_DROP_ENABLE_FUSE_N_I <= 1;
		COMP_USES_REF_I <= 1;
		SLEEP_SELECT_FIELD_I <= 3'h2;
		settle();
		chk("clock gated", MAIN_CLK_RUN_O, 1'b0);
		chk("scan off", SCAN_PORT_EN_O, 1'b0);
		chk("comparator ref", REF_ON_O, 1'b1);
		@(posedge CLK_I);
		COMP_USES_REF_I <= 0;
		ADC_ENABLE_I <= 1;
		settle();
		chk("extended", ADC_EXTENDED_O, 1'b1);
		@(posedge CLK_I);
		ADC_ENABLE_I <= 0;
		SLEEP_ACTIVE_I <= 0;
		settle();
		chk("ref idle", REF_ON_O, 1'b0);
		$display("sleep gating done");
	endtask : t_sleep
	task t_scan;
		@(posedge CLK_I);
		SCAN_PORT_DISABLE_BIT_I <= 0;
		SCAN_SHIFTING_I <= 1;
		SCAN_TDO_I <= 1;
		settle();
		chk("scan on", SCAN_PORT_EN_O, 1'b1);
		chk("tdo driven", TDO_OE_N_O, 1'b0);
		chk("tdo value", TDO_OUT_O, 1'b1);
		@(posedge CLK_I);
		SCAN_SHIFTING_I <= 0;
		SCAN_PORT_ENABLE_FUSE_N_I <= 1;
		settle();
		chk("tdo float", TDO_OE_N_O, 1'b1);
		chk("fuse off", SCAN_PORT_EN_O, 1'b0);
		$display("scan port done");
	endtask : t_scan
	initial begin
		settle();
		chk("reset core", CORE_RESET_O, 1'b1);
		chk("reset ports", PORT_RESET_O, 1'b1);
		@(posedge CLK_I);
		RST_I <= 0;
		t_sources();
		t_drop();
		t_sleep();
		t_scan();
		stop_test();
	end
endmodule : tb_rsc_reset_ctrl
`default_nettype wire
